// ===== verilog/logic_cell_input_select_gate.sv
// data selection multiplexers and gate three term select of a configurable logic cell
// Summary of operation
// - four stages, register configured, changeable while running
// - sixteen candidate inputs numbered zero to fifteen
// - four eight-input multiplexers drive selected data
// - inputs form four groups; mux sees two
// - each group feeds two muxes, different partners
// - each multiplexer passes exactly one input
// - three-bit select, codes ascend with input
// - mux one picks inputs zero to seven
// - mux two picks inputs four to eleven
// - mux three picks inputs eight to fifteen
// - mux four picks twelve-fifteen then zero-three
// - inputs zero-nine common, twelve-fifteen per instance
// - select fields held in two registers
// - select settings undefined until software writes; reset here loads zero codes
// - odd term bits admit true mux outputs
// - even term bits admit inverted mux outputs
`timescale 1ns/10ps
`default_nettype none
`include "logic_cell_map.svh"
module logic_cell_input_select_gate
  import logic_cell_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // candidate sources
  input wire logic cell_pin_input_a,
  input wire logic cell_pin_input_b,
  input wire logic comparator_one_synced,
  input wire logic comparator_two_synced,
  input wire logic sys_osc,
  input wire logic timer_zero_rollover,
  input wire logic timer_one_rollover,
  input wire logic timer_two_period_hit,
  input wire logic cell_one_result,
  input wire logic cell_two_result,
  input wire logic [1:0] reserved_in,
  input wire logic [3:0] instance_in,
  // selected data and gate three result
  output logic selected_data_one,
  output logic selected_data_two,
  output logic selected_data_three,
  output logic selected_data_four,
  output logic gate_three_out
);

  // candidate lines in input-number order
  cand_t cand; // candidate bus
  logic [7:0] input_select_reg_low_r; // mux one in 2:0, mux two in 6:4
  logic [7:0] input_select_reg_low_nxt;
  logic [7:0] input_select_reg_high_r; // mux three in 2:0, mux four in 6:4
  logic [7:0] input_select_reg_high_nxt;
  logic [7:0] gate_three_term_select_r; // term admit bits
  logic [7:0] gate_three_term_select_nxt;
  logic sel_written_r; // both select registers written since reset
  logic sel_written_nxt;
  logic [1:0] sel_seen_r; // which select registers were written
  logic [1:0] sel_seen_nxt;
  // bus side state
  logic ack_r; // bus acknowledge
  logic ack_nxt;
  logic [31:0] rdat_r; // read data
  logic [31:0] rdat_nxt;
  // decoded select codes and multiplexer data
  mux_sel_t mux_one_select, mux_two_select, mux_three_select, mux_four_select;
  logic [7:0] mux_in [4]; // per multiplexer inputs
  logic [3:0] sel_data; // multiplexer outputs
  // accepted requests, blocked while ack stands so one cycle is one access
  logic wr_req; // write accepted at this edge
  logic rd_req; // read accepted at this edge

  // candidate inputs: 0-9 fixed kinds, 10-11 reserved, 12-15 per instance
  // reserved lines stay selectable so software sees whatever drives them
  assign cand = {instance_in, reserved_in, cell_two_result, cell_one_result,
                 timer_two_period_hit, timer_one_rollover, timer_zero_rollover, sys_osc,
                 comparator_two_synced, comparator_one_synced, cell_pin_input_b, cell_pin_input_a};

  // select fields from two registers
  assign mux_one_select = input_select_reg_low_r[`SEL_FIELD_LO];
  assign mux_two_select = input_select_reg_low_r[`SEL_FIELD_HI];
  assign mux_three_select = input_select_reg_high_r[`SEL_FIELD_LO];
  assign mux_four_select = input_select_reg_high_r[`SEL_FIELD_HI];

  // group wiring: each group of four reaches two multiplexers
  assign mux_in[0] = cand[7:0];
  assign mux_in[1] = cand[11:4];
  assign mux_in[2] = cand[15:8];
  // mux four sees group four then group one, so it wraps past fifteen
  assign mux_in[3] = {cand[3:0], cand[15:12]};

  // one input per multiplexer, combinational path from sources
  always_comb begin
    // each code is the input position inside its multiplexer window
    sel_data[0] = mux_in[0][mux_one_select];
    sel_data[1] = mux_in[1][mux_two_select];
    sel_data[2] = mux_in[2][mux_three_select];
    sel_data[3] = mux_in[3][mux_four_select];
  end

  // selections leave the block unregistered
  assign selected_data_one = sel_data[0];
  assign selected_data_two = sel_data[1];
  assign selected_data_three = sel_data[2];
  assign selected_data_four = sel_data[3];

  // gate three: OR of admitted true (odd bits) and inverted (even bits) terms
  always_comb begin
    gate_three_out = 1'b0;
    // odd bit admits the true term, even bit the inverted term
    for (int i = 0; i < 4; i++) begin
      if (gate_three_term_select_r[2*i+1]) begin
        gate_three_out = gate_three_out | sel_data[i];
      end
      if (gate_three_term_select_r[2*i]) begin
        gate_three_out = gate_three_out | ~sel_data[i];
      end
    end
  end

  // a request counts once: while ack stands the same cycle is not taken again
  assign wr_req = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
  assign rd_req = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_r;

  // register file next state; writes land at the ack edge
  always_comb begin
    // hold the registers and read data unless a request changes them; ack follows the request
    input_select_reg_low_nxt = input_select_reg_low_r;
    input_select_reg_high_nxt = input_select_reg_high_r;
    gate_three_term_select_nxt = gate_three_term_select_r;
    sel_seen_nxt = sel_seen_r;
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    rdat_nxt = rdat_r;
    // only lane zero carries register bits; other lanes are ignored
    if (wr_req && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        `SEL_LOW_OFF: begin
          // spare bits 3 and 7 are not stored
          input_select_reg_low_nxt = {1'b0, wb_dat_i[6:4], 1'b0, wb_dat_i[2:0]};
          sel_seen_nxt[0] = 1'b1;
        end
        `SEL_HIGH_OFF: begin
          input_select_reg_high_nxt = {1'b0, wb_dat_i[6:4], 1'b0, wb_dat_i[2:0]};
          sel_seen_nxt[1] = 1'b1;
        end
        `G3_TERM_OFF: begin
          gate_three_term_select_nxt = wb_dat_i[7:0];
        end
        default: begin
          // unmapped or status: write ignored
        end
      endcase
    end
    // read data is registered so it stands together with ack
    if (rd_req) begin
      unique case (wb_adr_i)
        `SEL_LOW_OFF: rdat_nxt = {24'h00_0000, input_select_reg_low_r};
        `SEL_HIGH_OFF: rdat_nxt = {24'h00_0000, input_select_reg_high_r};
        `G3_TERM_OFF: rdat_nxt = {24'h00_0000, gate_three_term_select_r};
        `STATUS_OFF: rdat_nxt = {26'h0, sel_written_r, gate_three_out, sel_data};
        default: rdat_nxt = `UNMAPPED_DATA;
      endcase
    end
    // flag for software: both select registers hold written codes
    sel_written_nxt = &sel_seen_nxt;
  end

  // register update; select values undefined by spec, cleared here for determinism
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // known zero codes instead of undefined ones
      input_select_reg_low_r <= `SEL_RESET;
      input_select_reg_high_r <= `SEL_RESET;
      gate_three_term_select_r <= `G3_RESET;
      sel_seen_r <= 2'h0;
      sel_written_r <= 1'b0;
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      // every register loads its next value on each edge
      input_select_reg_low_r <= input_select_reg_low_nxt;
      input_select_reg_high_r <= input_select_reg_high_nxt;
      gate_three_term_select_r <= gate_three_term_select_nxt;
      sel_seen_r <= sel_seen_nxt;
      sel_written_r <= sel_written_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // bus outputs straight from their flip-flops
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // writes to the term register show after the ack edge
  term_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_req && wb_sel_i[0] && wb_adr_i == `G3_TERM_OFF) |=> gate_three_term_select_r == $past(wb_dat_i[7:0]))
    else $error("term write not applied");

  // mux one follows its select
  mux_one_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
    selected_data_one == cand[mux_one_select]) else $error("mux one wrong");

  // mux two offset by four
  mux_two_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
    selected_data_two == cand[4'(mux_two_select) + 4'h4]) else $error("mux two wrong");

  // mux three offset by eight
  mux_three_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
    selected_data_three == cand[4'(mux_three_select) + 4'h8]) else $error("mux three wrong");

  // mux four wraps from fifteen to zero
  mux_four_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
    selected_data_four == cand[4'(mux_four_select) + 4'hC]) else $error("mux four wrong");

  // no term admitted gives zero
  gate_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    (gate_three_term_select_r == 8'h00) |-> !gate_three_out) else $error("gate not zero");

  // true and inverted of one mux together force one
  gate_true_inv_a: assert property (@(posedge sys_clk) disable iff (rst)
    (gate_three_term_select_r[1:0] == 2'h3) |-> gate_three_out) else $error("gate not one");

  // single true term passes mux four
  gate_true_four_a: assert property (@(posedge sys_clk) disable iff (rst)
    (gate_three_term_select_r == 8'h80) |-> gate_three_out == selected_data_four)
    else $error("gate term four wrong");

  // ack lasts one cycle
  bus_ack_once_a: assert property (@(posedge sys_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack held");

  // an accepted request is answered at the next edge
  bus_ack_next_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack missing");

  // no answer without a request
  bus_ack_req_a: assert property (@(posedge sys_clk) disable iff (rst)
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");

  // select low write lands at the next edge, spare bits dropped
  sel_low_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_req && wb_sel_i[0] && wb_adr_i == `SEL_LOW_OFF) |=>
    input_select_reg_low_r == ($past(wb_dat_i[7:0]) & 8'h77)) else $error("select low write not applied");

  // select high write lands at the next edge, spare bits dropped
  sel_high_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_req && wb_sel_i[0] && wb_adr_i == `SEL_HIGH_OFF) |=>
    input_select_reg_high_r == ($past(wb_dat_i[7:0]) & 8'h77)) else $error("select high write not applied");

  // a write with lane zero off changes nothing
  lane_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_req && !wb_sel_i[0]) |=> $stable(gate_three_term_select_r) && $stable(input_select_reg_low_r)
    && $stable(input_select_reg_high_r)) else $error("masked write changed a register");

  // term register holds unless written
  term_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !(wr_req && wb_sel_i[0] && wb_adr_i == `G3_TERM_OFF) |=> $stable(gate_three_term_select_r))
    else $error("term changed without write");

  // select registers hold unless written
  sel_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !(wr_req && wb_sel_i[0] && (wb_adr_i == `SEL_LOW_OFF || wb_adr_i == `SEL_HIGH_OFF)) |=>
    $stable(input_select_reg_low_r) && $stable(input_select_reg_high_r)) else $error("select changed without write");

  // spare select bits never hold a one
  sel_spare_a: assert property (@(posedge sys_clk) disable iff (rst)
    (input_select_reg_low_r & 8'h88) == 8'h00 && (input_select_reg_high_r & 8'h88) == 8'h00)
    else $error("spare select bit set");

  // term read returns the register with the answer
  term_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_req && wb_adr_i == `G3_TERM_OFF) |=> wb_dat_o == {24'h00_0000, $past(gate_three_term_select_r)})
    else $error("term read wrong");

  // select low read returns the register with the answer
  sel_low_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_req && wb_adr_i == `SEL_LOW_OFF) |=> wb_dat_o == {24'h00_0000, $past(input_select_reg_low_r)})
    else $error("select low read wrong");

  // select high read returns the register with the answer
  sel_high_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_req && wb_adr_i == `SEL_HIGH_OFF) |=> wb_dat_o == {24'h00_0000, $past(input_select_reg_high_r)})
    else $error("select high read wrong");

  // status read reports the selections, the gate and the written flag
  status_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_req && wb_adr_i == `STATUS_OFF) |=> wb_dat_o[3:0] == $past(sel_data)
    && wb_dat_o[4] == $past(gate_three_out) && wb_dat_o[5] == $past(sel_written_r))
    else $error("status read wrong");

  // read data carries nothing above the byte
  rdata_upper_a: assert property (@(posedge sys_clk) disable iff (rst)
    wb_dat_o[31:8] == 24'h00_0000) else $error("read data upper bits set");

  // unmapped reads return zero
  unmapped_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_req && wb_adr_i != `SEL_LOW_OFF && wb_adr_i != `SEL_HIGH_OFF && wb_adr_i != `G3_TERM_OFF
    && wb_adr_i != `STATUS_OFF) |=> wb_dat_o == `UNMAPPED_DATA)
    else $error("unmapped read not zero");

  // written flag only after both select registers
  sel_written_a: assert property (@(posedge sys_clk) disable iff (rst)
    sel_written_r |-> (sel_seen_r == 2'h3)) else $error("written flag early");

  // single inverted term of mux one
  gate_inv_one_a: assert property (@(posedge sys_clk) disable iff (rst)
    (gate_three_term_select_r == 8'h01) |-> gate_three_out == !selected_data_one)
    else $error("gate inverted term one wrong");

  // single true term of mux one
  gate_true_one_a: assert property (@(posedge sys_clk) disable iff (rst)
    (gate_three_term_select_r == 8'h02) |-> gate_three_out == selected_data_one)
    else $error("gate true term one wrong");

  // all true terms give the OR of the four selections
  gate_all_true_a: assert property (@(posedge sys_clk) disable iff (rst)
    (gate_three_term_select_r == 8'hAA) |-> gate_three_out == (selected_data_one || selected_data_two
    || selected_data_three || selected_data_four)) else $error("gate all true wrong");

  // all inverted terms give one unless every selection is high
  gate_all_inv_a: assert property (@(posedge sys_clk) disable iff (rst)
    (gate_three_term_select_r == 8'h55) |-> gate_three_out == !(selected_data_one && selected_data_two
    && selected_data_three && selected_data_four)) else $error("gate all inverted wrong");

  // all candidates low drive every selection low
  mux_all_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    (cand == 16'h0000) |-> sel_data == 4'h0) else $error("selection high with no source high");

  // all candidates high drive every selection high
  mux_all_high_a: assert property (@(posedge sys_clk) disable iff (rst)
    (cand == 16'hFFFF) |-> sel_data == 4'hF) else $error("selection low with every source high");

endmodule
`default_nettype wire

// ===== verilog/logic_cell_map.svh
// register offsets, field positions and reset values of the logic cell input stage
`ifndef LOGIC_CELL_MAP_SVH
`define LOGIC_CELL_MAP_SVH
`define SEL_LOW_OFF 4'h0
`define SEL_HIGH_OFF 4'h4
`define G3_TERM_OFF 4'h8
`define STATUS_OFF 4'hC
`define SEL_FIELD_LO 2:0
`define SEL_FIELD_HI 6:4
`define SEL_RESET 8'h00
`define G3_RESET 8'h00
`define UNMAPPED_DATA 32'h0000_0000
`endif

// ===== verilog/logic_cell_pkg.sv
// types shared by the logic cell input stage
package logic_cell_pkg;
  typedef logic [2:0] mux_sel_t; // one multiplexer select code
  typedef logic [15:0] cand_t; // the sixteen candidate inputs
endpackage

// ===== sim/source_model.sv
// stand-in for the pins and peripherals that feed the cell candidates
`timescale 1ns/10ps
`default_nettype none
module source_model
  import logic_cell_pkg::*;
(
  input wire cand_t pattern,
  output logic [15:0] cand
);
  // each of the sixteen sources holds the level asked of it, numbered 0 to 15
  assign cand = pattern;
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the cell input select and gate three stage
`timescale 1ns/10ps
`default_nettype none
`include "logic_cell_map.svh"
module testbench;
  import logic_cell_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  cand_t pattern = 16'h0000; // levels asked of the sources
  logic [15:0] cand; // candidate lines as driven
  logic [3:0] sd; // selected data four down to one
  logic g3; // gate three result
  logic [31:0] rd; // last read data
  logic [7:0] g3_exp = 8'h66; // gate result per single term bit for pattern 8080
  int num_errors = 0;
  int tests_run = 0;
  source_model src (.pattern(pattern), .cand(cand));
  logic_cell_input_select_gate uut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cell_pin_input_a(cand[0]), .cell_pin_input_b(cand[1]),
    .comparator_one_synced(cand[2]), .comparator_two_synced(cand[3]), .sys_osc(cand[4]),
    .timer_zero_rollover(cand[5]), .timer_one_rollover(cand[6]), .timer_two_period_hit(cand[7]),
    .cell_one_result(cand[8]), .cell_two_result(cand[9]), .reserved_in(cand[11:10]),
    .instance_in(cand[15:12]), .selected_data_one(sd[0]), .selected_data_two(sd[1]),
    .selected_data_three(sd[2]), .selected_data_four(sd[3]), .gate_three_out(g3));
  // 40 MHz clock
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // verdict and end of run
  task automatic final_report();
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    int n;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge sys_clk);
    rd = wb_dat_o;
    if (wb_ack_o !== 1'b1) begin
      check("bus ack", {31'h0, wb_ack_o}, 32'h1);
      final_report();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // set source levels and let them settle
  task automatic drive(input cand_t p);
    @(posedge sys_clk);
    pattern <= p;
    @(negedge sys_clk);
  endtask
  // write the term register, set the sources and compare gate three
  task automatic gate_case(input logic [7:0] term, input cand_t p, input logic exp);
    wb_xfer(1'b1, `G3_TERM_OFF, {24'h0, term}, 4'h1);
    drive(p);
    check("gate mix", {31'h0, g3}, {31'h0, exp});
  endtask
  // expected selections four..one for a common select code
  function automatic logic [3:0] exp_sel(input cand_t p, input int c);
    return {p[(12 + c) % 16], p[8 + c], p[4 + c], p[c]};
  endfunction
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    wb_xfer(1'b0, `G3_TERM_OFF, 32'h0, 4'hF);
    check("term after reset", rd, 32'h0);
    check("gate idle", {31'h0, g3}, 32'h0);
    wb_xfer(1'b0, `STATUS_OFF, 32'h0, 4'hF);
    check("status after reset", rd, 32'h0);
    // every code on every multiplexer against every one-hot source
    for (int c = 0; c < 8; c++) begin
      wb_xfer(1'b1, `SEL_LOW_OFF, {25'h0, c[2:0], 1'b0, c[2:0]}, 4'h1);
      wb_xfer(1'b1, `SEL_HIGH_OFF, {25'h0, c[2:0], 1'b0, c[2:0]}, 4'h1);
      wb_xfer(1'b0, `SEL_HIGH_OFF, 32'h0, 4'hF);
      check("select high", rd, {25'h0, c[2:0], 1'b0, c[2:0]});
      for (int i = 0; i < 16; i++) begin
        drive(cand_t'(1) << i);
        check("mux outs", {28'h0, sd}, {28'h0, exp_sel(cand_t'(1) << i, c)});
      end
    end
    // codes are 7: d1=in7 d2=in11 d3=in15 d4=in3, so pattern 8080 gives d4..d1 = 0101
    drive(16'h8080);
    for (int b = 0; b < 8; b++) begin
      wb_xfer(1'b1, `G3_TERM_OFF, 32'h1 << b, 4'h1);
      wb_xfer(1'b0, `G3_TERM_OFF, 32'h0, 4'hF);
      check("term readback", rd, 32'h1 << b);
      drive(16'h8080);
      check("gate three", {31'h0, g3}, {31'h0, g3_exp[b]});
    end
    // lane zero off: write dropped
    wb_xfer(1'b1, `G3_TERM_OFF, 32'hFF, 4'h0);
    wb_xfer(1'b0, `G3_TERM_OFF, 32'h0, 4'hF);
    check("masked write", rd, 32'h80);
    wb_xfer(1'b1, 4'h2, 32'hFF, 4'hF);
    wb_xfer(1'b0, 4'h2, 32'h0, 4'hF);
    check("unmapped", rd, `UNMAPPED_DATA);
    wb_xfer(1'b0, `STATUS_OFF, 32'h0, 4'hF);
    check("status", rd, 32'h25);
    // spare select bits are not stored; codes stay 7
    wb_xfer(1'b1, `SEL_LOW_OFF, 32'hFF, 4'h1);
    wb_xfer(1'b0, `SEL_LOW_OFF, 32'h0, 4'hF);
    check("select spare", rd, 32'h77);
    // several terms at once, codes 7: 8080 gives d4..d1 = 0101
    gate_case(8'h03, 16'h0000, 1'b1);
    gate_case(8'hAA, 16'h8080, 1'b1);
    gate_case(8'hAA, 16'h0000, 1'b0);
    gate_case(8'h55, 16'h0000, 1'b1);
    gate_case(8'h55, 16'hFFFF, 1'b0);
    // second reset: codes back to 000, so only input 0 reaches mux one
    drive(16'h0001);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    wb_xfer(1'b0, `STATUS_OFF, 32'h0, 4'hF);
    check("status after second reset", rd, 32'h1);
    final_report();
  end
endmodule
`default_nettype wire
